// >>> common/ccs_consts.svh
// offsets, field positions and reset values of the card config/status block
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH
// apb byte addresses
`define CCS_ADDR_CFGSTAT 12'h000
`define CCS_ADDR_CTRL 12'h004
`define CCS_ADDR_PINSTAT 12'h008
// function_config_status field positions
`define CCS_BIT_SUMMARY 7
`define CCS_BIT_GATE 6
`define CCS_BIT_IO8 5
`define CCS_BIT_RSVD 4
`define CCS_BIT_AUDIO 3
`define CCS_BIT_PWRDN 2
`define CCS_BIT_INTR 1
`define CCS_BIT_ACKEN 0
// control register fields
`define CCS_CTRL_IOMODE 0
`define CCS_CTRL_PINREG 1
`define CCS_CTRL_MULTI 2
`define CCS_CTRL_HASPD 3
`define CCS_CFGSTAT_RST 8'h00
`define CCS_CTRL_RST 4'h0
`define CCS_PINCHG_RST 4'h0
// cycles the request line is released for a fresh notification
`define CCS_NOTIFY_CYCLES 4'h4
`endif

// >>> common/ccs_pkg.sv
// types of the card config/status block
`default_nettype none
package ccs_pkg;
   typedef enum logic [1:0] {CCS_IDLE, CCS_SETUP, CCS_ACCESS} ccs_apb_t;
   typedef logic [7:0] ccs_byte_t;
endpackage : ccs_pkg
`default_nettype wire

// >>> design/ccs_config_status.sv
// card function configuration and status register with apb access
// Operation
// - summary set when pin change bits or enabled extended events are set
// - summary and gate undefined outside io mode or without pin register
// - status change pin low when summary and gate both one in io mode
// - gate zero never lets status change pin go active
// - eight bit only flag stored; byte-wide register suits split accesses
// - audio routed to speaker only when enabled and configured
// - power-down request drives power-down state while card ready, unless function lacks one
// - pending bit follows the function's service request
// - pending writes ignored when no function enables acknowledge protocol
// - zero write to pending with protocol on re-notifies if service wanted
// - single function card ignores ack enable writes, reads zero
// - register present whenever audio, sharing or status needed
// - configuration index zero selects memory-only, io conditions off
// - four pin change bits set when their live bits change state
//
// The address map and the APB register port were left to the implementer.
`include "ccs_consts.svh"
`default_nettype none
module ccs_config_status (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic softReset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [5:0] configIndex,
   input wire logic [3:0] liveStatus,
   input wire logic [2:0] extEvent,
   input wire logic [2:0] extEnable,
   input wire logic serviceRequest,
   input wire logic otherAckEnable,
   input wire logic otherServiceRequest,
   input wire logic cardReady,
   input wire logic audioIn,
   output logic statusChangePin_n,
   output logic speakerAudioOut_n,
   output logic powerDownState,
   output logic cardInterruptRequest_n,
   output logic eightBitIoOnly
);
   import ccs_pkg::*;

   // ************************************************************
   // input synchronisers
   // ************************************************************
   logic [3:0] liveMeta_r, liveSync_r, livePrev_r;
   logic [6:0] evMeta_r, evSync_r;
   logic [3:0] miscMeta_r, miscSync_r;
   logic [5:0] cfgMeta_r, cfgSync_r;

   // two flops for every asynchronous pin
   always_ff @(posedge mclk) begin
      liveMeta_r <= liveStatus;
      liveSync_r <= liveMeta_r;
      livePrev_r <= liveSync_r;
      evMeta_r <= {extEvent, extEnable, serviceRequest};
      evSync_r <= evMeta_r;
      miscMeta_r <= {otherAckEnable, otherServiceRequest, cardReady, audioIn};
      miscSync_r <= miscMeta_r;
      cfgMeta_r <= configIndex;
      cfgSync_r <= cfgMeta_r;
   end

   // ************************************************************
   // apb decode
   // ************************************************************
   // one compare per register; shared by the three address hits
   function automatic logic addrIs(input logic [11:0] a, input logic [11:0] base);
      return (a == base);
   endfunction : addrIs

   ccs_apb_t apbState_r;
   logic [7:0] cfgStat_r;
   logic [3:0] ctrl_r;
   logic [3:0] pinChg_r;
   logic [3:0] pinChg_nxt;
   logic notify_r;
   logic [3:0] notifyCnt_r;
   wire logic anyReset = !rst_n || softReset;
   wire logic wrAcc = psel && penable && pwrite && pready;
   wire logic rdAcc = psel && !pwrite && !penable;
   wire logic hitCs = addrIs(paddr, `CCS_ADDR_CFGSTAT);
   wire logic hitCtrl = addrIs(paddr, `CCS_ADDR_CTRL);
   wire logic hitPin = addrIs(paddr, `CCS_ADDR_PINSTAT);
   wire logic mapped = hitCs || hitCtrl || hitPin;
   wire logic wrCs = wrAcc && hitCs && pstrb[0];
   wire logic wrCtrl = wrAcc && hitCtrl && pstrb[0];
   wire logic wrPin = wrAcc && hitPin && pstrb[0];

   // ************************************************************
   // mode qualifiers
   // ************************************************************
   wire logic configured = (cfgSync_r != 6'h00);
   wire logic ioMode = configured && ctrl_r[`CCS_CTRL_IOMODE];
   wire logic pinRegOn = ctrl_r[`CCS_CTRL_PINREG];
   wire logic multiFunc = ctrl_r[`CCS_CTRL_MULTI];
   wire logic [2:0] evBits = evSync_r[6:4];
   wire logic [2:0] enBits = evSync_r[3:1];
   wire logic svcReq = evSync_r[0];
   wire logic otherAck = miscSync_r[3];
   wire logic otherSvc = miscSync_r[2];
   wire logic readySync = miscSync_r[1];
   wire logic audioSync = miscSync_r[0];

   // summary only meaningful in io mode with the pin register present
   wire logic summary = ioMode && pinRegOn
      && ((|pinChg_r) || (|(evBits & enBits)));
   wire logic gateOn = cfgStat_r[`CCS_BIT_GATE];
   wire logic ackAny = cfgStat_r[`CCS_BIT_ACKEN] || otherAck;
   wire logic pendWrZero = wrCs && !pwdata[`CCS_BIT_INTR] && ackAny;
   wire logic anySvc = (svcReq && cfgStat_r[`CCS_BIT_ACKEN]) || otherSvc;
   wire logic pdAllowed = readySync && ctrl_r[`CCS_CTRL_HASPD];

   // pin change bits: live edge sets, masked host write, set wins
   wire logic [3:0] liveEdge = liveSync_r ^ livePrev_r;
   always_comb begin
      pinChg_nxt = pinChg_r;
      if (wrPin) begin
         pinChg_nxt = (pinChg_r & ~pwdata[3:0]) | (pwdata[7:4] & pwdata[3:0]);
      end
      pinChg_nxt = pinChg_nxt | liveEdge;
   end

   // read mux; reserved bit reads zero
   wire logic [7:0] csView = {summary, cfgStat_r[6:5], 1'b0, cfgStat_r[3:2],
      svcReq, cfgStat_r[0]};
   wire logic [31:0] rdMux = hitCs ? {24'h000000, csView} :
      hitCtrl ? {28'h0000000, ctrl_r} :
      hitPin ? {24'h000000, pinChg_r, liveSync_r} : 32'h00000000;

   // ************************************************************
   // apb slave: no wait state, pready in access phase
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         apbState_r <= CCS_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (rdAcc) begin
            prdata <= rdMux;
         end
         apbState_r <= psel ? (penable ? CCS_IDLE : CCS_ACCESS) : CCS_IDLE;
      end
   end

   // config/status writable fields, reset clears them all
   always_ff @(posedge mclk) begin
      if (anyReset) begin
         cfgStat_r <= `CCS_CFGSTAT_RST;
      end else if (wrCs) begin
         cfgStat_r[`CCS_BIT_GATE] <= pwdata[`CCS_BIT_GATE];
         cfgStat_r[`CCS_BIT_IO8] <= pwdata[`CCS_BIT_IO8];
         cfgStat_r[`CCS_BIT_AUDIO] <= pwdata[`CCS_BIT_AUDIO];
         cfgStat_r[`CCS_BIT_PWRDN] <= pwdata[`CCS_BIT_PWRDN]
            && ctrl_r[`CCS_CTRL_HASPD];
         cfgStat_r[`CCS_BIT_ACKEN] <= pwdata[`CCS_BIT_ACKEN] && multiFunc;
      end
   end

   // control register and pin change bits
   always_ff @(posedge mclk) begin
      if (anyReset) begin
         ctrl_r <= `CCS_CTRL_RST;
         pinChg_r <= `CCS_PINCHG_RST;
      end else begin
         if (wrCtrl) begin
            ctrl_r <= pwdata[3:0];
         end
         pinChg_r <= pinChg_nxt;
      end
   end

   // re-notification: request line released for a few cycles, then re-driven
   // so an edge-sensitive host sees a fresh request
   always_ff @(posedge mclk) begin
      if (anyReset) begin
         notify_r <= 1'b0;
         notifyCnt_r <= 4'h0;
      end else if (pendWrZero && anySvc) begin
         notify_r <= 1'b1;
         notifyCnt_r <= `CCS_NOTIFY_CYCLES;
      end else if (notifyCnt_r != 4'h0) begin
         notifyCnt_r <= notifyCnt_r - 4'h1;
         notify_r <= (notifyCnt_r != 4'h1);
      end
   end

   // ************************************************************
   // registered outputs
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (anyReset) begin
         statusChangePin_n <= 1'b1;
         speakerAudioOut_n <= 1'b1;
         powerDownState <= 1'b0;
         cardInterruptRequest_n <= 1'b1;
         eightBitIoOnly <= 1'b0;
      end else begin
         statusChangePin_n <= !(summary && gateOn && ioMode);
         speakerAudioOut_n <= !(cfgStat_r[`CCS_BIT_AUDIO] && configured
            && audioSync);
         powerDownState <= cfgStat_r[`CCS_BIT_PWRDN] && pdAllowed;
         cardInterruptRequest_n <= !(svcReq && ioMode && !notify_r);
         eightBitIoOnly <= cfgStat_r[`CCS_BIT_IO8];
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   // each property names its own reset: fields clear on either reset, the bus on rst_n only

   // gate low keeps the pin idle one cycle later
   a_gate_blocks_pin: assert property (@(posedge mclk) disable iff (!rst_n)
      !$past(gateOn) |-> statusChangePin_n)
      else $error("pin active while gate off");

   // summary and gate together drive the pin
   a_pin_follows_sum: assert property (@(posedge mclk) disable iff (anyReset)
      (summary && gateOn && ioMode) |=> !statusChangePin_n)
      else $error("pin not active");

   // memory-only mode never shows a status change
   a_memonly_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
      (!$past(configured) && !$past(configured, 2)) |-> statusChangePin_n)
      else $error("status pin active in memory mode");

   // a pending change bit shows as summary on readback
   a_summary_read: assert property (@(posedge mclk) disable iff (anyReset)
      (rdAcc && hitCs && ioMode && pinRegOn && (|pinChg_r)) |=> prdata[`CCS_BIT_SUMMARY])
      else $error("summary missing for change bit");

   // an enabled extended event shows as summary on readback
   a_summary_ext: assert property (@(posedge mclk) disable iff (anyReset)
      (rdAcc && hitCs && ioMode && pinRegOn && (|(evBits & enBits))) |=> prdata[7])
      else $error("summary missing for event");

   // outside io mode the summary reads as zero
   a_summary_quiet: assert property (@(posedge mclk) disable iff (anyReset)
      (rdAcc && hitCs && !ioMode) |=> !prdata[`CCS_BIT_SUMMARY])
      else $error("summary set outside io mode");

   // live edge sets its change bit even against a host clear
   a_change_sets: assert property (@(posedge mclk) disable iff (anyReset)
      (liveEdge != 4'h0) |=> ((pinChg_r & $past(liveEdge)) == $past(liveEdge)))
      else $error("change bit not set");

   // speaker silent while unconfigured
   a_audio_gated: assert property (@(posedge mclk) disable iff (!rst_n)
      !$past(configured) |-> speakerAudioOut_n)
      else $error("audio while unconfigured");

   // speaker follows audio once enabled and configured
   a_audio_on: assert property (@(posedge mclk) disable iff (anyReset)
      (cfgStat_r[`CCS_BIT_AUDIO] && configured && audioSync) |=> !speakerAudioOut_n)
      else $error("audio not routed");

   // stored request enters power-down
   a_pdown_follows: assert property (@(posedge mclk) disable iff (anyReset)
      (cfgStat_r[`CCS_BIT_PWRDN] && pdAllowed) |=> powerDownState)
      else $error("power-down not entered");

   // a function without a power-down state ignores the request
   a_pdown_ignored: assert property (@(posedge mclk) disable iff (anyReset)
      !ctrl_r[`CCS_CTRL_HASPD] |=> !powerDownState)
      else $error("power-down without such state");

   // eight bit flag copied to its output
   a_io8_copy: assert property (@(posedge mclk) disable iff (anyReset)
      cfgStat_r[`CCS_BIT_IO8] |=> eightBitIoOnly)
      else $error("eight bit flag not shown");

   // pending bit read back is the request seen at the setup edge
   a_pend_readback: assert property (@(posedge mclk) disable iff (!rst_n)
      (rdAcc && hitCs) |=> (prdata[`CCS_BIT_INTR] == $past(svcReq)))
      else $error("pending mismatch");

   // request line follows service request outside a re-notification
   a_irq_follows: assert property (@(posedge mclk) disable iff (anyReset)
      (svcReq && ioMode && !notify_r) |=> !cardInterruptRequest_n)
      else $error("request line not driven");

   // no request line without service request
   a_irq_idle: assert property (@(posedge mclk) disable iff (anyReset)
      !svcReq |=> cardInterruptRequest_n)
      else $error("request line without request");

   // pending writes do nothing while no function enables the protocol
   a_pend_ignored: assert property (@(posedge mclk) disable iff (anyReset)
      (wrCs && !ackAny && !notify_r) |=> !notify_r)
      else $error("pending write not ignored");

   // zero write with service wanted releases the line for the full count
   a_renotify_pulse: assert property (@(posedge mclk) disable iff (anyReset)
      (pendWrZero && anySvc) |=> notify_r[*4])
      else $error("no re-notification");

   // the release ends when the count runs out
   a_renotify_ends: assert property (@(posedge mclk) disable iff (anyReset)
      ((notifyCnt_r == 4'h1) && !(pendWrZero && anySvc)) |=> !notify_r)
      else $error("re-notification does not end");

   // single-function card stores no acknowledge enable
   a_ack_single_zero: assert property (@(posedge mclk) disable iff (anyReset)
      (wrCs && !multiFunc) |=> !cfgStat_r[`CCS_BIT_ACKEN])
      else $error("ack set on single function");

   // hardware reset clears every field
   a_reset_clears: assert property (@(posedge mclk)
      $past(!rst_n) |-> (cfgStat_r == `CCS_CFGSTAT_RST))
      else $error("fields not cleared");

   // soft reset clears fields and control alike
   a_soft_clears: assert property (@(posedge mclk)
      $past(softReset) |-> ((cfgStat_r == `CCS_CFGSTAT_RST) && (ctrl_r == `CCS_CTRL_RST)))
      else $error("fields not cleared by soft reset");

   // ready only in the access phase
   a_apb_access: assert property (@(posedge mclk) disable iff (!rst_n)
      pready |-> (apbState_r == CCS_ACCESS))
      else $error("ready outside access phase");

   // ready stands for a single cycle
   a_pready_once: assert property (@(posedge mclk) disable iff (!rst_n)
      pready |=> !pready)
      else $error("ready held too long");

   // main scenarios worth seeing at least once
   c_status_pin: cover property (@(posedge mclk) !statusChangePin_n);
   c_renotify: cover property (@(posedge mclk) pendWrZero && anySvc);
   c_power_down: cover property (@(posedge mclk) powerDownState);
   c_audio_on: cover property (@(posedge mclk) !speakerAudioOut_n);
   c_summary_read: cover property (@(posedge mclk) rdAcc && hitCs && summary);
endmodule : ccs_config_status
`default_nettype wire

// >>> verif/card_config_status_register_tb.sv
// self-checking bench for the card config/status register
`include "ccs_consts.svh"
`default_nettype none
module card_config_status_register_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_n, softReset, psel, penable, pwrite, pready, pslverr, slvErr;
   logic serviceRequest, cardReady, audioIn, shareCmd, reqCmd, oAck, oReq, seen;
   logic statusChangePin_n, speakerAudioOut_n, powerDownState, cardIrq_n, io8;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0] configIndex;
   logic [3:0] liveStatus;
   logic [2:0] extEvent, extEnable;
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;
   ccs_config_status u_dut (.mclk(mclk), .rst_n(rst_n), .softReset(softReset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .configIndex(configIndex),
      .liveStatus(liveStatus), .extEvent(extEvent), .extEnable(extEnable),
      .serviceRequest(serviceRequest), .otherAckEnable(oAck), .otherServiceRequest(oReq),
      .cardReady(cardReady), .audioIn(audioIn), .statusChangePin_n(statusChangePin_n),
      .speakerAudioOut_n(speakerAudioOut_n), .powerDownState(powerDownState),
      .cardInterruptRequest_n(cardIrq_n), .eightBitIoOnly(io8));
   ccs_host_model u_host (.mclk(mclk), .rst_n(rst_n), .shareCmd(shareCmd), .reqCmd(reqCmd),
      .otherAckEnable(oAck), .otherServiceRequest(oReq));
   //****************************************
   // bus and check helpers
   //****************************************
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // hold the request until pready is seen at an edge
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      slvErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // async inputs need three cycles to show; one spare
   task automatic settle();
      repeat (4) @(posedge mclk);
   endtask : settle
   // note any high level on the request line over ten cycles
   task automatic watch();
      seen = 1'b0;
      repeat (10) begin
         @(posedge mclk);
         if (cardIrq_n === 1'b1) seen = 1'b1;
      end
   endtask : watch
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   //****************************************
   // scenarios
   //****************************************
   task automatic t_status();
      apb(1, `CCS_ADDR_CTRL, 32'h0000000F);
      liveStatus <= 4'h1;
      settle();
      apb(0, `CCS_ADDR_PINSTAT, 0);
      chk(rd, 32'h00000011);
      apb(1, `CCS_ADDR_CFGSTAT, 32'h00000040);
      settle();
      chk(statusChangePin_n, 1'b0);
      apb(0, `CCS_ADDR_CFGSTAT, 0);
      chk(rd, 32'h000000C0);
      apb(1, `CCS_ADDR_CFGSTAT, 32'h00000000);
      settle();
      chk(statusChangePin_n, 1'b1);
      apb(1, `CCS_ADDR_PINSTAT, 32'h00000001);
      extEvent <= 3'h2;
      extEnable <= 3'h2;
      settle();
      apb(0, `CCS_ADDR_CFGSTAT, 0);
      chk(rd, 32'h00000080);
      extEvent <= 3'h0;
      $display("status test done");
   endtask : t_status
   task automatic t_audio_power();
      audioIn <= 1'b1;
      cardReady <= 1'b1;
      apb(1, `CCS_ADDR_CFGSTAT, 32'h0000002C);
      settle();
      chk({speakerAudioOut_n, powerDownState, io8}, 3'b011);
      configIndex <= 6'h00;
      apb(1, `CCS_ADDR_CFGSTAT, 32'h00000008);
      settle();
      chk({speakerAudioOut_n, powerDownState}, 2'b10);
      configIndex <= 6'h01;
      $display("audio power test done");
   endtask : t_audio_power
   task automatic t_intr();
      apb(1, `CCS_ADDR_CTRL, 32'h00000003);
      serviceRequest <= 1'b1;
      apb(1, `CCS_ADDR_CFGSTAT, 32'h00000001);
      settle();
      apb(0, `CCS_ADDR_CFGSTAT, 0);
      chk(rd, 32'h00000002);
      apb(1, `CCS_ADDR_CFGSTAT, 32'h00000000);
      watch();
      chk(seen, 1'b0);
      apb(1, `CCS_ADDR_CTRL, 32'h00000007);
      shareCmd <= 1'b1;
      apb(1, `CCS_ADDR_CFGSTAT, 32'h00000001);
      settle();
      apb(1, `CCS_ADDR_CFGSTAT, 32'h00000001);
      watch();
      chk({seen, cardIrq_n}, 2'b10);
      apb(0, `CCS_ADDR_CFGSTAT, 0);
      chk(rd, 32'h00000003);
      $display("interrupt test done");
   endtask : t_intr
   task automatic t_reset();
      serviceRequest <= 1'b0;
      softReset <= 1'b1;
      settle();
      softReset <= 1'b0;
      apb(0, `CCS_ADDR_CFGSTAT, 0);
      chk(rd, 32'h00000000);
      apb(0, 12'h00C, 0);
      chk(rd, 32'h00000000);
      chk(slvErr, 1'b1);
      $display("reset test done");
   endtask : t_reset
   // clock and hang guard
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         stop_test();
      end
   end
   // main sequence
   initial begin
      {rst_n, softReset, psel, penable, pwrite, serviceRequest, cardReady} = '0;
      {audioIn, shareCmd, reqCmd, paddr, pwdata, liveStatus, extEvent, extEnable} = '0;
      configIndex = 6'h01;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      reqCmd <= 1'b1;
      t_status();
      t_audio_power();
      t_intr();
      t_reset();
      stop_test();
   end
endmodule : card_config_status_register_tb
`default_nettype wire

// >>> verif/ccs_host_model.sv
// model of the card's second function as seen by host interrupt software
`default_nettype none
module ccs_host_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic shareCmd,
   input wire logic reqCmd,
   output logic otherAckEnable,
   output logic otherServiceRequest
);
   timeunit 1ns;
   timeprecision 1ps;
   // software enables sharing here too; request only counts once shared
   always_ff @(posedge mclk) begin
      otherAckEnable <= rst_n & shareCmd;
      otherServiceRequest <= rst_n & shareCmd & reqCmd;
   end
endmodule : ccs_host_model
`default_nettype wire
